/* File: src/scan_tap_pkg.sv */
// constants and types for the boundary-scan test port
// shared by the test port top; no timescale needed here
package scan_tap_pkg;

    localparam int INSTR_W = 3;
    localparam int IDENT_W = 32;
    localparam int CHAIN_LEN = 109;
    localparam int SYNC_DEPTH = 3;
    localparam int MODE_W = 3;

    // instruction codes, bit 2 most significant
    localparam logic [2:0] INS_EXTEST = 3'h0;
    localparam logic [2:0] INS_IDENT = 3'h1;
    localparam logic [2:0] INS_SAMPLEZ = 3'h2;
    localparam logic [2:0] INS_SAMPLE = 3'h4;
    localparam logic [2:0] INS_BYPASS = 3'h7;

    // reset value and capture pattern of the instruction path
    localparam logic [2:0] INSTR_RESET = INS_IDENT;
    localparam logic [2:0] INSTR_CAPTURE = 3'h1;

    // identification word; value is arbitrary, bit 0 kept high
    localparam logic [31:0] IDENT_VALUE = 32'h0A5C_3E01;

    // positions of the mode levels handed to the core clock
    localparam int MODE_EXTEST = 0;
    localparam int MODE_HIGHZ = 1;
    localparam int MODE_ODTOFF = 2;

    typedef enum logic [15:0] {
        ST_RESET = 16'h0001,
        ST_IDLE = 16'h0002,
        ST_SEL_DR = 16'h0004,
        ST_CAP_DR = 16'h0008,
        ST_SHIFT_DR = 16'h0010,
        ST_EXIT1_DR = 16'h0020,
        ST_PAUSE_DR = 16'h0040,
        ST_EXIT2_DR = 16'h0080,
        ST_UPD_DR = 16'h0100,
        ST_SEL_IR = 16'h0200,
        ST_CAP_IR = 16'h0400,
        ST_SHIFT_IR = 16'h0800,
        ST_EXIT1_IR = 16'h1000,
        ST_PAUSE_IR = 16'h2000,
        ST_EXIT2_IR = 16'h4000,
        ST_UPD_IR = 16'h8000
    } tap_state_t;

endpackage : scan_tap_pkg

/* File: src/scan_tap.sv */
// boundary-scan test port: controller, scan registers, ball control
// assumes tck comes from the external test controller and may stop;
// rst is the power-up reset on ref_clk and must span three tck edges
`timescale 1ns/1ps
`default_nettype none

module scan_tap
    import scan_tap_pkg::*;
(
    // core clock and power-up reset
    input wire logic ref_clk,
    input wire logic rst,
    // test link
    input wire logic tck,
    input wire logic tms,
    input wire logic tdi,
    output logic tdo,
    output logic tdoEn,
    // memory balls seen by the chain
    input wire logic [CHAIN_LEN:1] ballIn,
    output logic [CHAIN_LEN:1] ballOut,
    // ball control on the core clock
    output logic testDrive,
    output logic outputsHighZ,
    output logic odtOff
);

    // power-up reset carried into the test clock domain
    logic [SYNC_DEPTH-1:0] rstSync_q;
    logic rstTck;

    always_ff @(posedge tck) begin
        rstSync_q <= {rstSync_q[SYNC_DEPTH-2:0], rst};
    end

    // act only while the second and third stage are both high
    assign rstTck = rstSync_q[1] & rstSync_q[2];

    // controller state machine
    tap_state_t state_q;
    tap_state_t state_d;

    always_comb begin
        case (state_q)
            ST_RESET: state_d = tms ? ST_RESET : ST_IDLE;
            ST_IDLE: state_d = tms ? ST_SEL_DR : ST_IDLE;
            ST_SEL_DR: state_d = tms ? ST_SEL_IR : ST_CAP_DR;
            ST_CAP_DR: state_d = tms ? ST_EXIT1_DR : ST_SHIFT_DR;
            ST_SHIFT_DR: state_d = tms ? ST_EXIT1_DR : ST_SHIFT_DR;
            ST_EXIT1_DR: state_d = tms ? ST_UPD_DR : ST_PAUSE_DR;
            ST_PAUSE_DR: state_d = tms ? ST_EXIT2_DR : ST_PAUSE_DR;
            ST_EXIT2_DR: state_d = tms ? ST_UPD_DR : ST_SHIFT_DR;
            ST_UPD_DR: state_d = tms ? ST_SEL_DR : ST_IDLE;
            ST_SEL_IR: state_d = tms ? ST_RESET : ST_CAP_IR;
            ST_CAP_IR: state_d = tms ? ST_EXIT1_IR : ST_SHIFT_IR;
            ST_SHIFT_IR: state_d = tms ? ST_EXIT1_IR : ST_SHIFT_IR;
            ST_EXIT1_IR: state_d = tms ? ST_UPD_IR : ST_PAUSE_IR;
            ST_PAUSE_IR: state_d = tms ? ST_EXIT2_IR : ST_PAUSE_IR;
            ST_EXIT2_IR: state_d = tms ? ST_UPD_IR : ST_SHIFT_IR;
            ST_UPD_IR: state_d = tms ? ST_SEL_DR : ST_IDLE;
            default: state_d = ST_RESET;
        endcase
    end

    always_ff @(posedge tck) begin
        if (rstTck) begin
            state_q <= ST_RESET;
        end else begin
            state_q <= state_d;
        end
    end

    // scan registers
    logic [INSTR_W-1:0] instrShift_q, instrShift_d;
    logic [INSTR_W-1:0] instrSelect_q, instrSelect_d;
    logic bypassBit_q, bypassBit_d;
    logic [IDENT_W-1:0] identShift_q, identShift_d;
    logic [CHAIN_LEN:1] chain_q, chain_d;
    logic [CHAIN_LEN:1] ballOut_q, ballOut_d;
    logic selIdent;
    logic selChain;
    logic updChain;

    always_comb begin
        // reserved codes fall back to the bypass path
        selIdent = (instrSelect_q == INS_IDENT);
        selChain = (instrSelect_q == INS_EXTEST) || (instrSelect_q == INS_SAMPLEZ)
            || (instrSelect_q == INS_SAMPLE);
        updChain = (instrSelect_q == INS_EXTEST) || (instrSelect_q == INS_SAMPLE);
        instrShift_d = instrShift_q;
        instrSelect_d = instrSelect_q;
        bypassBit_d = bypassBit_q;
        identShift_d = identShift_q;
        chain_d = chain_q;
        ballOut_d = ballOut_q;
        case (state_q)
            ST_RESET: instrSelect_d = INSTR_RESET;
            ST_CAP_IR: instrShift_d = INSTR_CAPTURE;
            ST_SHIFT_IR: instrShift_d = {tdi, instrShift_q[INSTR_W-1:1]};
            ST_UPD_IR: instrSelect_d = instrShift_q;
            ST_CAP_DR: begin
                identShift_d = IDENT_VALUE;
                bypassBit_d = 1'b0;
                // balls may move against tck; a bad capture is only a bad value
                if (selChain) begin
                    chain_d = ballIn;
                end
            end
            ST_SHIFT_DR: begin
                if (selIdent) begin
                    identShift_d = {tdi, identShift_q[IDENT_W-1:1]};
                end else if (selChain) begin
                    chain_d = {tdi, chain_q[CHAIN_LEN:2]};
                end else begin
                    bypassBit_d = tdi;
                end
            end
            ST_UPD_DR: begin
                // preload under sample lands here, ready for extest
                if (updChain) begin
                    ballOut_d = chain_q;
                end
            end
            default: ;
        endcase
    end

    always_ff @(posedge tck) begin
        if (rstTck) begin
            instrShift_q <= INSTR_RESET;
            instrSelect_q <= INSTR_RESET;
            bypassBit_q <= 1'b0;
            identShift_q <= IDENT_VALUE;
            chain_q <= '0;
            ballOut_q <= '0;
        end else begin
            instrShift_q <= instrShift_d;
            instrSelect_q <= instrSelect_d;
            bypassBit_q <= bypassBit_d;
            identShift_q <= identShift_d;
            chain_q <= chain_d;
            ballOut_q <= ballOut_d;
        end
    end

    assign ballOut = ballOut_q;

    // serial output, moved on the falling edge
    logic tdo_q, tdo_d;
    logic tdoEn_q, tdoEn_d;

    always_comb begin
        tdoEn_d = (state_q == ST_SHIFT_IR) || (state_q == ST_SHIFT_DR);
        if (state_q == ST_SHIFT_IR) begin
            tdo_d = instrShift_q[0];
        end else if (selIdent) begin
            tdo_d = identShift_q[0];
        end else if (selChain) begin
            tdo_d = chain_q[1];
        end else begin
            tdo_d = bypassBit_q;
        end
    end

    always_ff @(negedge tck) begin
        if (rstTck) begin
            tdo_q <= 1'b0;
            tdoEn_q <= 1'b0;
        end else begin
            tdo_q <= tdo_d;
            tdoEn_q <= tdoEn_d;
        end
    end

    assign tdo = tdo_q;
    assign tdoEn = tdoEn_q;

    // mode levels registered on tck so the crossing sees no decode glitch
    logic [MODE_W-1:0] mode_q, mode_d;

    // decoded from the next instruction: tck may stop right after update-ir
    always_comb begin
        mode_d = '0;
        mode_d[MODE_EXTEST] = (instrSelect_d == INS_EXTEST);
        mode_d[MODE_HIGHZ] = (instrSelect_d == INS_SAMPLEZ);
        mode_d[MODE_ODTOFF] = (instrSelect_d == INS_EXTEST) || (instrSelect_d == INS_SAMPLEZ)
            || (instrSelect_d == INS_SAMPLE);
    end

    always_ff @(posedge tck) begin
        if (rstTck) begin
            mode_q <= '0;
        end else begin
            mode_q <= mode_d;
        end
    end

    // core side: three stages, a bit moves once stages two and three agree
    logic [MODE_W-1:0] modeS1_q, modeS2_q, modeS3_q;
    logic [MODE_W-1:0] modeOut_q, modeOut_d;

    always_comb begin
        for (int i = 0; i < MODE_W; i++) begin
            modeOut_d[i] = (modeS2_q[i] == modeS3_q[i]) ? modeS2_q[i] : modeOut_q[i];
        end
    end

    always_ff @(posedge ref_clk) begin
        if (rst) begin
            modeS1_q <= '0;
            modeS2_q <= '0;
            modeS3_q <= '0;
            modeOut_q <= '0;
        end else begin
            modeS1_q <= mode_q;
            modeS2_q <= modeS1_q;
            modeS3_q <= modeS2_q;
            modeOut_q <= modeOut_d;
        end
    end

    // core output data is not routed here, so it is undefined under extest
    assign testDrive = modeOut_q[MODE_EXTEST];
    assign outputsHighZ = modeOut_q[MODE_HIGHZ];
    assign odtOff = modeOut_q[MODE_ODTOFF];

    // checks
    chk_five_ones: assert property (@(posedge tck) disable iff (rstTck)
        tms [*5] |=> state_q == ST_RESET)
        else $error("five tms-high edges did not reach reset state");

    chk_reset_ident: assert property (@(posedge tck) disable iff (rstTck)
        state_q == ST_RESET |=> instrSelect_q == INS_IDENT)
        else $error("instruction not ident after reset state");

    chk_update_commit: assert property (@(posedge tck) disable iff (rstTck)
        state_q == ST_UPD_IR |=> instrSelect_q == $past(instrShift_q))
        else $error("update-ir did not commit shifted instruction");

    chk_ir_hold: assert property (@(posedge tck) disable iff (rstTck)
        state_q != ST_UPD_IR && state_q != ST_RESET |=> $stable(instrSelect_q))
        else $error("instruction changed outside update-ir");

    chk_ident_capture: assert property (@(posedge tck) disable iff (rstTck)
        state_q == ST_CAP_DR ##1 state_q == ST_SHIFT_DR && selIdent |-> tdo_d == IDENT_VALUE[0])
        else $error("ident word not presented after capture");

    chk_bypass_path: assert property (@(posedge tck) disable iff (rstTck)
        state_q == ST_SHIFT_DR && instrSelect_q == INS_BYPASS |=> bypassBit_q == $past(tdi))
        else $error("bypass bit did not take tdi");

    chk_chain_capture: assert property (@(posedge tck) disable iff (rstTck)
        state_q == ST_CAP_DR && selChain |=> chain_q == $past(ballIn))
        else $error("chain did not capture balls");

    chk_extest_update: assert property (@(posedge tck) disable iff (rstTck)
        state_q == ST_UPD_DR && instrSelect_q == INS_EXTEST |=> ballOut_q == $past(chain_q))
        else $error("extest update did not drive chain contents");

    chk_ir_capture: assert property (@(posedge tck) disable iff (rstTck)
        state_q == ST_CAP_IR ##1 state_q == ST_SHIFT_IR |-> instrShift_q == INSTR_CAPTURE)
        else $error("instruction capture pattern wrong");

    chk_odt_highz: assert property (@(posedge ref_clk) disable iff (rst)
        outputsHighZ || testDrive |-> odtOff)
        else $error("termination on during scan mode");

    chk_mode_update: assert property (@(posedge tck) disable iff (rstTck)
        state_q == ST_UPD_IR |=> mode_q[MODE_EXTEST] == (instrSelect_q == INS_EXTEST))
        else $error("extest level did not follow update-ir");

    chk_shift_enable: assert property (@(posedge tck) disable iff (rstTck)
        state_q == ST_SHIFT_DR || state_q == ST_SHIFT_IR |-> tdoEn_q)
        else $error("tdo enable low during shift");

endmodule : scan_tap

`default_nettype wire

/* File: verification/jtag_host.sv */
// test controller model: drives tck, tms and tdi of the test port
// assumes one task runs at a time; tck stands still between calls
`timescale 1ns/1ps
`default_nettype none

module jtag_host (
    // test link
    output logic tck,
    output logic tms,
    output logic tdi,
    input wire logic tdo
);
    initial begin
        tck = 1'b0;
        tms = 1'b1;
        tdi = 1'b1;
    end

    // one 6 ns period; tdo taken before the rise, as it moved on the fall
    task automatic pulse(input logic m, input logic d, output logic o);
        tms = m;
        tdi = d;
        #3;
        o = tdo;
        tck = 1'b1;
        #3;
        tck = 1'b0;
    endtask : pulse

    task automatic walk(input int n, input logic m);
        logic o;
        for (int i = 0; i < n; i++) begin
            pulse(m, 1'b1, o);
        end
    endtask : walk

    // idle to capture, n shifts lsb first, update, back to idle
    task automatic scan(input logic ir, input int n, input logic [127:0] din, output logic [127:0] dout);
        logic o;
        dout = '0;
        walk(1, 1'b1);
        if (ir) walk(1, 1'b1);
        walk(2, 1'b0);
        for (int i = 0; i < n; i++) begin
            pulse(i == n - 1, din[i], o);
            dout[i] = o;
        end
        walk(1, 1'b1);
        walk(1, 1'b0);
    endtask : scan
endmodule : jtag_host

`default_nettype wire

/* File: verification/scan_tap_tb.sv */
// self-checking bench of the boundary-scan test port
// assumes jtag_host as the external test controller
`timescale 1ns/1ps
`default_nettype none

module scan_tap_tb;
    import scan_tap_pkg::*;
    logic ref_clk = 1'b0;
    logic rst = 1'b1;
    logic tck, tms, tdi, tdo, tdoEn, testDrive, outputsHighZ, odtOff;
    logic [CHAIN_LEN:1] ballIn = '0;
    logic [CHAIN_LEN:1] ballOut;
    logic [127:0] dout, din, held;
    logic [31:0] rnd = 32'h67C41F75;
    logic [2:0] codes [3] = '{INS_SAMPLE, INS_EXTEST, INS_SAMPLEZ};
    int bad_count = 0;
    int samples_checked = 0;
    int cycles = 0;
    int enRises = 0;

    always #20 ref_clk = ~ref_clk;

    scan_tap scan_tap_inst (.ref_clk(ref_clk), .rst(rst), .tck(tck), .tms(tms), .tdi(tdi), .tdo(tdo),
        .tdoEn(tdoEn), .ballIn(ballIn), .ballOut(ballOut), .testDrive(testDrive),
        .outputsHighZ(outputsHighZ), .odtOff(odtOff));
    jtag_host jtag_host_inst (.tck(tck), .tms(tms), .tdi(tdi), .tdo(tdo));

    function automatic logic [31:0] xorshift(input logic [31:0] s);
        logic [31:0] x;
        x = s ^ (s << 13);
        x = x ^ (x >> 17);
        return x ^ (x << 5);
    endfunction : xorshift

    function automatic logic [127:0] expectBypass(input logic [127:0] d, input int n);
        return {d[126:0], 1'b0} & ((128'h1 << n) - 128'h1);
    endfunction : expectBypass

    function automatic logic [2:0] expectModes(input logic [2:0] c);
        return {c == INS_EXTEST, c == INS_SAMPLEZ, c == INS_EXTEST || c == INS_SAMPLEZ || c == INS_SAMPLE};
    endfunction : expectModes

    task automatic draw(output logic [127:0] v);
        v = '0;
        repeat (4) begin
            rnd = xorshift(rnd);
            v = {v[95:0], rnd};
        end
    endtask : draw

    task automatic check(input logic [127:0] seen, input logic [127:0] exp, input string what);
        samples_checked++;
        if (seen !== exp) begin
            bad_count++;
            $display("wrong value at %0t: %s seen %0h expected %0h", $time, what, seen, exp);
        end
    endtask : check

    task automatic test_done();
        $display("checks %0d, mismatches %0d", samples_checked, bad_count);
        if (bad_count == 0 && samples_checked > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask : test_done

    // tck must keep running while rst is high
    task automatic powerUp();
        @(posedge ref_clk) rst <= 1'b1;
        fork
            jtag_host_inst.walk(40, 1'b1);
            begin
                repeat (4) @(posedge ref_clk);
                rst <= 1'b0;
            end
        join
        jtag_host_inst.walk(1, 1'b0);
        repeat (6) @(posedge ref_clk);
        @(negedge ref_clk);
    endtask : powerUp

    task automatic loadIr(input logic [2:0] c);
        jtag_host_inst.scan(1'b1, 3, {125'h0, c}, dout);
        check(dout[2:0], INSTR_CAPTURE, "ir capture");
        repeat (6) @(posedge ref_clk);
        @(negedge ref_clk);
        check({testDrive, outputsHighZ, odtOff}, expectModes(c), "modes");
    endtask : loadIr

    task automatic identRead(input string what);
        int enBefore;
        draw(din);
        enBefore = enRises;
        jtag_host_inst.scan(1'b0, 32, din, dout);
        check(dout, IDENT_VALUE, what);
        check(enRises - enBefore, 32, "tdo enable span");
    endtask : identRead

    initial begin
        powerUp();
        check({testDrive, outputsHighZ, odtOff}, 3'h0, "modes after reset");
        identRead("ident after power-up");
        $display("test ident done");
        loadIr(INS_BYPASS);
        draw(din);
        jtag_host_inst.scan(1'b0, 8, din, dout);
        check(dout, expectBypass(din, 8), "bypass path");
        jtag_host_inst.walk(5, 1'b1);
        jtag_host_inst.walk(1, 1'b0);
        identRead("ident after tms reset");
        $display("test bypass and tms reset done");
        // sample first so extest starts from a preloaded vector
        held = '0;
        foreach (codes[k]) begin
            loadIr(codes[k]);
            check(ballOut, held, "update kept");
            draw(din);
            @(posedge ref_clk) ballIn <= din[108:0];
            @(posedge ref_clk);
            draw(din);
            jtag_host_inst.scan(1'b0, CHAIN_LEN, din, dout);
            check(dout, ballIn, "chain capture");
            if (codes[k] != INS_SAMPLEZ) held = din & ((128'h1 << CHAIN_LEN) - 128'h1);
            check(ballOut, held, "chain update");
            $display("test chain code %0h done", codes[k]);
        end
        // power-up conditions again after samplez
        powerUp();
        check({testDrive, outputsHighZ, odtOff}, 3'h0, "modes after second reset");
        identRead("ident after second reset");
        $display("test second reset done");
        test_done();
    end

    // tdo enable counted on the edges that take shifted bits
    always @(posedge tck) begin
        if (tdoEn === 1'b1) begin
            enRises <= enRises + 1;
        end
    end

    always @(posedge ref_clk) begin
        cycles++;
        if (cycles == 4000) begin
            bad_count++;
            test_done();
        end
    end
endmodule : scan_tap_tb

`default_nettype wire
